// ---- rtl/spc_pkg.sv ----
// Shared constants and carrier types of the synchronous DRAM pin interface.
// Assumes one clock; every pin is presented synchronously to it.
package spc_pkg;

	localparam int BANK_W = 2;
	localparam int BANKS = 4;
	localparam int ROW_W = 12;
	localparam int COL_W = 8;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int LEN_W = 4;
	localparam int AUTO_CLOSE_BIT = 10;
	// Only the low row bits reach the model array; a full array would not fit a simulator.
	localparam int MEM_ROW_W = 2;
	localparam int MEM_AW = BANK_W + MEM_ROW_W + COL_W;
	localparam int MEM_DEPTH = 1 << MEM_AW;
	localparam int BUF_DEPTH = 2;

	localparam int MODE_LEN_LSB = 0;
	localparam int MODE_LEN_W = 3;
	localparam logic [MODE_LEN_W-1:0] LEN_FULL_PAGE = 3'h7;
	localparam logic [ROW_W-1:0] MODE_RESET = 12'h000;
	localparam logic [COL_W-1:0] FULL_PAGE_WRAP = 8'hFF;

	typedef struct packed {
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [BANK_W-1:0] bank_select;
		logic [ROW_W-1:0] address_bus;
		logic [LANES-1:0] byte_mask;
		logic [DATA_W-1:0] data_lines;
	} spc_pins_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [MEM_AW-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [LANES-1:0] wen;
	} spc_mem_req_t;

	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_OPEN,
		CMD_CLOSE,
		CMD_READ,
		CMD_WRITE,
		CMD_MODE,
		CMD_REFRESH,
		CMD_STOP
	} spc_cmd_t;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_POWER_DOWN,
		ST_SELF_REFRESH
	} spc_power_t;

endpackage

// ---- rtl/spc_mem.sv ----
// Cell array of the model: byte-lane writes and a registered read port.
// Assumes the caller never reads and writes the same word in one cycle.
`timescale 1ns/1ns
module spc_mem import spc_pkg::*; (
	input wire logic clock,
	input wire logic resetn,
	input wire spc_mem_req_t req,
	output logic [DATA_W-1:0] rdata
);

	logic [DATA_W-1:0] cells [MEM_DEPTH];

	always_ff @(posedge clock) begin
		for (int i = 0; i < LANES; i++) begin
			if (req.wr && req.wen[i]) begin
				cells[req.addr][i*LANE_W +: LANE_W] <= req.wdata[i*LANE_W +: LANE_W];
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata <= '0;
		end else if (req.rd) begin
			rdata <= cells[req.addr];
		end
	end

endmodule

// ---- rtl/spc_sdram_pins.sv ----
// Command and data pin interface of a four-bank 32-bit synchronous DRAM.
// Assumes the memory controller honours bank timing; no timing is checked here.
`timescale 1ns/1ns
module spc_sdram_pins import spc_pkg::*; (
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic CKE,
	input wire logic CS_N,
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic WE_N,
	input wire logic [BANK_W-1:0] BANK_SELECT,
	input wire logic [ROW_W-1:0] ADDRESS_BUS,
	input wire logic [LANES-1:0] BYTE_MASK,
	input wire logic [DATA_W-1:0] DATA_LINES_IN,
	output logic [DATA_W-1:0] DATA_LINES_OUT,
	output logic [LANES-1:0] DATA_LINES_OE,
	output logic LOW_POWER
);

	typedef struct packed {
		spc_pins_t pins;
		logic cke_prev;
		logic cke_sync1;
		logic cke_sync2;
		spc_power_t power;
		logic [ROW_W-1:0] mode;
		logic [BANK_W-1:0] mode_bank;
		logic [BANKS-1:0] bank_open;
		logic [BANKS-1:0][ROW_W-1:0] row;
		logic bursting;
		logic writing;
		logic auto_close;
		logic [BANK_W-1:0] burst_bank;
		logic [COL_W-1:0] col;
		logic [LEN_W-1:0] left;
		logic rd_pend;
		logic [BUF_DEPTH-1:0][DATA_W-1:0] buf_data;
		logic buf_wp;
		logic buf_rp;
		logic [1:0] buf_cnt;
		logic [DATA_W-1:0] dq_out;
		logic [LANES-1:0] dq_oe;
		logic low_power;
	} spc_state_t;

	spc_state_t s;
	spc_state_t next_s;
	spc_cmd_t cmd;
	spc_mem_req_t req;
	logic [DATA_W-1:0] rdata;
	logic cmd_valid;
	logic frozen;
	logic full;
	logic space;
	logic start;
	logic advance;
	logic go;
	logic lp_enter;
	logic push;
	logic pop;
	logic [LEN_W-1:0] len;
	logic [LEN_W-1:0] after;
	logic [COL_W-1:0] wrap;
	logic [COL_W-1:0] act_col;
	logic [BANK_W-1:0] act_bank;

	always_comb begin
		cmd_valid = s.power == ST_RUN && s.cke_prev && !s.pins.cs_n;
		case ({s.pins.ras_n, s.pins.cas_n, s.pins.we_n})
			3'h3: cmd = CMD_OPEN;
			3'h2: cmd = CMD_CLOSE;
			3'h5: cmd = CMD_READ;
			3'h4: cmd = CMD_WRITE;
			3'h0: cmd = CMD_MODE;
			3'h1: cmd = CMD_REFRESH;
			3'h6: cmd = CMD_STOP;
			default: cmd = CMD_NONE;
		endcase
		if (!cmd_valid) begin
			cmd = CMD_NONE;
		end
		full = s.mode[MODE_LEN_LSB +: MODE_LEN_W] == LEN_FULL_PAGE;
		case (s.mode[MODE_LEN_LSB +: MODE_LEN_W])
			3'h1: len = 4'h2;
			3'h2: len = 4'h4;
			3'h3: len = 4'h8;
			default: len = 4'h1;
		endcase
		wrap = full ? FULL_PAGE_WRAP : COL_W'(len - 4'h1);
		// A clock gate sampled low stalls bursts and read data from the following cycle, and commands one cycle later.
		frozen = !s.pins.cke;
		// Room is counted against words in flight so a stall never drops a read word.
		// A word leaving this cycle frees its slot, which keeps reads at one word per edge.
		pop = s.power == ST_RUN && !frozen && s.buf_cnt != 2'h0;
		space = 2'(s.buf_cnt + {1'b0, s.rd_pend} - {1'b0, pop}) < 2'(BUF_DEPTH);
		start = (cmd == CMD_READ || cmd == CMD_WRITE) && !frozen
			&& (cmd == CMD_WRITE || space) && s.bank_open[s.pins.bank_select];
		advance = s.bursting && !frozen && !start && cmd != CMD_STOP
			&& (s.writing || space);
		go = start || advance;
		act_bank = start ? s.pins.bank_select : s.burst_bank;
		act_col = start ? s.pins.address_bus[COL_W-1:0] : s.col;
		after = start ? len - 4'h1 : s.left - 4'h1;
		lp_enter = s.power == ST_RUN && s.cke_prev && frozen && s.bank_open == '0
			&& !s.bursting && s.buf_cnt == 2'h0 && !s.rd_pend
			&& (cmd == CMD_NONE || cmd == CMD_REFRESH);
		push = s.rd_pend;
		req.rd = go && (start ? cmd == CMD_READ : !s.writing);
		req.wr = go && (start ? cmd == CMD_WRITE : s.writing);
		req.addr = {act_bank, s.row[act_bank][MEM_ROW_W-1:0], act_col};
		req.wdata = s.pins.data_lines;
		req.wen = ~s.pins.byte_mask;
	end

	always_comb begin
		next_s = s;
		next_s.cke_sync1 = CKE;
		next_s.cke_sync2 = s.cke_sync1;
		next_s.rd_pend = req.rd;
		case (s.power)
			ST_RUN: begin
				next_s.pins = {CKE, CS_N, RAS_N, CAS_N, WE_N, BANK_SELECT, ADDRESS_BUS,
					BYTE_MASK, DATA_LINES_IN};
				next_s.cke_prev = s.pins.cke;
				if (lp_enter) begin
					next_s.power = (cmd == CMD_REFRESH) ? ST_SELF_REFRESH : ST_POWER_DOWN;
					next_s.low_power = 1'b1;
				end
			end
			ST_POWER_DOWN, ST_SELF_REFRESH: begin
				// Pins stay frozen; only the synchronised clock gate is watched.
				if (s.cke_sync2) begin
					next_s.power = ST_RUN;
					next_s.low_power = 1'b0;
					next_s.pins.cke = 1'b1;
					next_s.pins.cs_n = 1'b1;
					next_s.cke_prev = 1'b1;
				end
			end
			default: begin
				next_s.power = ST_RUN;
			end
		endcase
		case (cmd)
			CMD_OPEN: begin
				next_s.bank_open[s.pins.bank_select] = 1'b1;
				next_s.row[s.pins.bank_select] = s.pins.address_bus;
			end
			CMD_CLOSE: begin
				if (s.pins.address_bus[AUTO_CLOSE_BIT]) begin
					next_s.bank_open = '0;
				end else begin
					next_s.bank_open[s.pins.bank_select] = 1'b0;
				end
			end
			CMD_MODE: begin
				next_s.mode = s.pins.address_bus;
				next_s.mode_bank = s.pins.bank_select;
			end
			CMD_STOP: begin
				next_s.bursting = 1'b0;
			end
			default: begin
			end
		endcase
		if (go) begin
			next_s.col = (act_col & ~wrap) | (COL_W'(act_col + 8'h01) & wrap);
			next_s.left = after;
			next_s.burst_bank = act_bank;
			next_s.bursting = 1'b1;
			if (start) begin
				next_s.writing = cmd == CMD_WRITE;
				next_s.auto_close = s.pins.address_bus[AUTO_CLOSE_BIT];
			end
			if (!full && after == 4'h0) begin
				next_s.bursting = 1'b0;
				if (start ? s.pins.address_bus[AUTO_CLOSE_BIT] : s.auto_close) begin
					next_s.bank_open[act_bank] = 1'b0;
				end
			end
		end
		if (push) begin
			next_s.buf_data[s.buf_wp] = rdata;
			next_s.buf_wp = !s.buf_wp;
		end
		if (pop) begin
			next_s.buf_rp = !s.buf_rp;
		end
		next_s.buf_cnt = 2'(s.buf_cnt + {1'b0, push} - {1'b0, pop});
		if (lp_enter || s.power != ST_RUN) begin
			next_s.dq_oe = '0;
		end else if (!frozen) begin
			next_s.dq_oe = '0;
			if (pop) begin
				next_s.dq_out = s.buf_data[s.buf_rp];
				next_s.dq_oe = ~s.pins.byte_mask;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			s <= '0;
			s.mode <= MODE_RESET;
		end else begin
			s <= next_s;
		end
	end

	spc_mem u_mem (
		.clock(CLOCK),
		.resetn(RESETN),
		.req(req),
		.rdata(rdata)
	);

	assign DATA_LINES_OUT = s.dq_out;
	assign DATA_LINES_OE = s.dq_oe;
	assign LOW_POWER = s.low_power;

	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESETN);

	property p_deselect_ignored;
		s.power == ST_RUN && s.pins.cs_n |=> $stable(s.bank_open) && $stable(s.mode);
	endproperty
	a_deselect_ignored: assert property (p_deselect_ignored) else $error("deselect changed state");

	property p_open_row;
		cmd == CMD_OPEN |=> s.bank_open[$past(s.pins.bank_select)]
			&& s.row[$past(s.pins.bank_select)] == $past(s.pins.address_bus);
	endproperty
	a_open_row: assert property (p_open_row) else $error("row open not latched");

	property p_close_all;
		cmd == CMD_CLOSE && s.pins.address_bus[AUTO_CLOSE_BIT] |=> s.bank_open == '0;
	endproperty
	a_close_all: assert property (p_close_all) else $error("close all left a bank open");

	property p_close_one;
		cmd == CMD_CLOSE && !s.pins.address_bus[AUTO_CLOSE_BIT] && !go
		|=> !s.bank_open[$past(s.pins.bank_select)];
	endproperty
	a_close_one: assert property (p_close_one) else $error("bank close missed");

	property p_mode_load;
		cmd == CMD_MODE |=> s.mode == $past(s.pins.address_bus);
	endproperty
	a_mode_load: assert property (p_mode_load) else $error("mode not loaded");

	property p_freeze;
		s.power == ST_RUN && frozen && !lp_enter
		|=> $stable(s.col) && $stable(DATA_LINES_OUT) && $stable(DATA_LINES_OE);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while suspended");

	property p_burst_advance;
		advance |=> s.col != $past(s.col);
	endproperty
	a_burst_advance: assert property (p_burst_advance) else $error("burst address stuck");

	property p_enter_low_power;
		lp_enter |=> LOW_POWER && s.power != ST_RUN && DATA_LINES_OE == '0;
	endproperty
	a_enter_low_power: assert property (p_enter_low_power) else $error("no low power entry");

	property p_no_capture;
		s.power != ST_RUN && !s.cke_sync2 |=> $stable(s.pins);
	endproperty
	a_no_capture: assert property (p_no_capture) else $error("input captured in low power");

	property p_exit;
		s.power != ST_RUN && s.cke_sync2 |=> s.power == ST_RUN ##1 !LOW_POWER;
	endproperty
	a_exit: assert property (p_exit) else $error("low power exit missed");

	property p_read_mask;
		pop |=> DATA_LINES_OE == ~$past(s.pins.byte_mask);
	endproperty
	a_read_mask: assert property (p_read_mask) else $error("read lane mask wrong");

	property p_write_mask;
		req.wr |-> (req.wen & s.pins.byte_mask) == '0 && s.power == ST_RUN;
	endproperty
	a_write_mask: assert property (p_write_mask) else $error("masked lane written");

	c_read_burst: cover property (start && cmd == CMD_READ ##3 DATA_LINES_OE != '0);
	c_write_burst: cover property (start && cmd == CMD_WRITE ##1 advance);
	c_power_down: cover property (s.power == ST_POWER_DOWN ##[1:20] s.power == ST_RUN);
	c_self_refresh: cover property (s.power == ST_SELF_REFRESH);

endmodule

// ---- bench/spc_ctrl_model.sv ----
// Memory controller pin stage: puts each requested pin set on the bus for one clock.
// Assumes the bench changes its request once per clock, just after the rising edge.
`timescale 1ns/1ns
module spc_ctrl_model import spc_pkg::*; (
	input wire logic clock,
	input wire logic resetn,
	input wire spc_pins_t req,
	output spc_pins_t pins
);
	// Idle pins are a clock-enabled no-operation, so the first real command decodes.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pins <= {5'h17, 50'h0};
		end else begin
			pins <= req;
		end
	end
endmodule

// ---- bench/spc_sdram_pins_test.sv ----
// Self-checking bench for the DRAM pin interface, driven through the controller model.
// Assumes a bounded read latency, so replies are awaited under a bounded count.
`timescale 1ns/1ns
module spc_sdram_pins_test import spc_pkg::*; ;
	localparam logic [3:0] C_NOP = 4'h7;
	localparam logic [3:0] C_OPEN = 4'h3;
	localparam logic [3:0] C_CLOSE = 4'h2;
	localparam logic [3:0] C_READ = 4'h5;
	localparam logic [3:0] C_WRITE = 4'h4;
	localparam logic [3:0] C_MODE = 4'h0;
	localparam logic [3:0] C_DESEL_READ = 4'hD;
	localparam logic [3:0] C_STOP = 4'h6;
	localparam logic [3:0] C_REFRESH = 4'h1;
	logic CLOCK = 1'b0;
	logic RESETN = 1'b0;
	spc_pins_t req = {5'h17, 50'h0};
	spc_pins_t pins;
	logic [DATA_W-1:0] dout;
	logic [LANES-1:0] oe;
	logic low_power;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;
	always #25 CLOCK = ~CLOCK;
	spc_ctrl_model partner (.clock(CLOCK), .resetn(RESETN), .req(req), .pins(pins));
	spc_sdram_pins DUT (.CLOCK(CLOCK), .RESETN(RESETN), .CKE(pins.cke), .CS_N(pins.cs_n),
		.RAS_N(pins.ras_n), .CAS_N(pins.cas_n), .WE_N(pins.we_n),
		.BANK_SELECT(pins.bank_select), .ADDRESS_BUS(pins.address_bus),
		.BYTE_MASK(pins.byte_mask), .DATA_LINES_IN(pins.data_lines),
		.DATA_LINES_OUT(dout), .DATA_LINES_OE(oe), .LOW_POWER(low_power));
	task automatic complete_run();
		if (failures == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk_data(string name, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk_flag(string name, logic [3:0] exp, logic [3:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic cmd(logic [3:0] c, logic [1:0] b, logic [11:0] a, logic [3:0] m,
		logic [31:0] d);
		@(posedge CLOCK);
		req <= {req.cke, c, b, a, m, d};
	endtask
	// Masked lanes carry no defined data, so only enabled lanes are compared.
	task automatic rd(logic [1:0] b, logic [11:0] a, logic [3:0] m, logic [31:0] e0,
		logic [31:0] e1, int n);
		int w;
		logic [31:0] lm;
		lm = {{8{~m[3]}}, {8{~m[2]}}, {8{~m[1]}}, {8{~m[0]}}};
		cmd(C_READ, b, a, m, 32'h0);
		cmd(C_NOP, 2'h0, 12'h0, m, 32'h0);
		w = 0;
		while (oe === 4'h0 && w < 8) begin
			@(posedge CLOCK);
			#1;
			w++;
		end
		if (n == 0) begin
			chk_flag("idle enable", 4'h0, oe);
		end else begin
			chk_flag("lane enable", ~m, oe);
			chk_data("first word", e0 & lm, dout & lm);
			if (n == 2) begin
				@(posedge CLOCK);
				#1;
				chk_data("second word", e1 & lm, dout & lm);
			end
		end
	endtask
	task automatic wait_lp(logic v);
		int w;
		w = 0;
		while (low_power !== v && w < 12) begin
			@(posedge CLOCK);
			#1;
			w++;
		end
		chk_flag("low power", {3'h0, v}, {3'h0, low_power});
	endtask
	task automatic t_masked_write();
		cmd(C_OPEN, 2'h1, 12'h005, 4'h0, 32'h0);
		cmd(C_WRITE, 2'h1, 12'h012, 4'h0, 32'hA1B2C3D4);
		cmd(C_WRITE, 2'h1, 12'h012, 4'h5, 32'h11223344);
		rd(2'h1, 12'h012, 4'h0, 32'h11B233D4, 32'h0, 1);
		rd(2'h1, 12'h012, 4'h2, 32'h11B233D4, 32'h0, 1);
	endtask
	task automatic t_deselect();
		int w;
		cmd(C_DESEL_READ, 2'h1, 12'h012, 4'h0, 32'h0);
		cmd(C_NOP, 2'h0, 12'h000, 4'h0, 32'h0);
		w = 0;
		while (oe === 4'h0 && w < 8) begin
			@(posedge CLOCK);
			#1;
			w++;
		end
		chk_flag("deselect enable", 4'h0, oe);
	endtask
	// A full-page burst runs until stopped, so exactly three words must come back.
	task automatic t_stop();
		int w;
		cmd(C_MODE, 2'h0, 12'h007, 4'h0, 32'h0);
		cmd(C_OPEN, 2'h0, 12'h001, 4'h0, 32'h0);
		cmd(C_WRITE, 2'h0, 12'h010, 4'h0, 32'h5A5A0010);
		cmd(C_NOP, 2'h0, 12'h000, 4'h0, 32'h5A5A0011);
		cmd(C_NOP, 2'h0, 12'h000, 4'h0, 32'h5A5A0012);
		cmd(C_STOP, 2'h0, 12'h000, 4'h0, 32'h5A5A0013);
		cmd(C_READ, 2'h0, 12'h010, 4'h0, 32'h0);
		cmd(C_NOP, 2'h0, 12'h000, 4'h0, 32'h0);
		cmd(C_NOP, 2'h0, 12'h000, 4'h0, 32'h0);
		cmd(C_STOP, 2'h0, 12'h000, 4'h0, 32'h0);
		w = 0;
		while (oe === 4'h0 && w < 8) begin
			@(posedge CLOCK);
			#1;
			w++;
		end
		chk_data("page word 0", 32'h5A5A0010, dout);
		@(posedge CLOCK);
		#1;
		chk_data("page word 1", 32'h5A5A0011, dout);
		@(posedge CLOCK);
		#1;
		chk_data("page word 2", 32'h5A5A0012, dout);
		@(posedge CLOCK);
		#1;
		chk_flag("stop enable", 4'h0, oe);
		cmd(C_CLOSE, 2'h0, 12'h400, 4'h0, 32'h0);
		cmd(C_NOP, 2'h0, 12'h000, 4'h0, 32'h0);
	endtask
	task automatic t_close();
		cmd(C_OPEN, 2'h0, 12'h000, 4'h0, 32'h0);
		cmd(C_CLOSE, 2'h0, 12'h000, 4'h0, 32'h0);
		rd(2'h0, 12'h012, 4'h0, 32'h0, 32'h0, 0);
		rd(2'h1, 12'h012, 4'h0, 32'h11B233D4, 32'h0, 1);
		cmd(C_CLOSE, 2'h0, 12'h400, 4'h0, 32'h0);
		rd(2'h1, 12'h012, 4'h0, 32'h0, 32'h0, 0);
	endtask
	task automatic t_burst();
		cmd(C_MODE, 2'h0, 12'h001, 4'h0, 32'h0);
		cmd(C_OPEN, 2'h2, 12'h003, 4'h0, 32'h0);
		cmd(C_WRITE, 2'h2, 12'h004, 4'h0, 32'h0BAD0001);
		cmd(C_NOP, 2'h0, 12'h000, 4'h0, 32'h0BAD0002);
		rd(2'h2, 12'h004, 4'h0, 32'h0BAD0001, 32'h0BAD0002, 2);
		rd(2'h2, 12'h005, 4'h0, 32'h0BAD0002, 32'h0BAD0001, 2);
		rd(2'h2, 12'h404, 4'h0, 32'h0BAD0001, 32'h0BAD0002, 2);
		rd(2'h2, 12'h004, 4'h0, 32'h0, 32'h0, 0);
	endtask
	// All banks are idle here, which the controller must ensure before entry.
	task automatic t_power();
		@(posedge CLOCK);
		req.cke <= 1'b0;
		wait_lp(1'b1);
		cmd(C_OPEN, 2'h3, 12'h000, 4'h0, 32'h0);
		cmd(C_NOP, 2'h0, 12'h000, 4'h0, 32'h0);
		@(posedge CLOCK);
		req.cke <= 1'b1;
		wait_lp(1'b0);
		rd(2'h3, 12'h000, 4'h0, 32'h0, 32'h0, 0);
		@(posedge CLOCK);
		req <= {1'b0, C_REFRESH, 2'h0, 12'h000, 4'h0, 32'h0};
		cmd(C_NOP, 2'h0, 12'h000, 4'h0, 32'h0);
		wait_lp(1'b1);
		@(posedge CLOCK);
		req.cke <= 1'b1;
		wait_lp(1'b0);
	endtask
	always @(posedge CLOCK) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			complete_run();
		end
	end
	initial begin
		repeat (6) @(posedge CLOCK);
		RESETN <= 1'b1;
		repeat (2) @(posedge CLOCK);
		t_masked_write();
		t_deselect();
		t_close();
		t_burst();
		t_stop();
		t_power();
		complete_run();
	end
endmodule
